// ==== csr_pkg.sv ====
/*
 * Shared constants for the configuration startup and readback sequencer:
 * APB register offsets, field positions, reset values and option encodings.
 * Assumes a 32-bit APB bus and a single 40 MHz clock.
 */
package csr_pkg;

   // ********************
   // Register offsets
   // ********************
   localparam logic [7:0] CSR_OPT_OFS = 8'h00;
   localparam logic [7:0] CSR_CTL_OFS = 8'h04;
   localparam logic [7:0] CSR_STAT_OFS = 8'h08;
   localparam logic [7:0] CSR_LEN_OFS = 8'h0c;
   localparam logic [7:0] CSR_RBD_OFS = 8'h10;

   // ********************
   // Option fields
   // ********************
   localparam int CSR_OPT_FIN_AFTER = 0;
   localparam int CSR_OPT_CLR_BEFORE = 1;
   localparam int CSR_OPT_ALIGN_FIN = 2;
   localparam int CSR_OPT_NOPULL = 3;
   localparam int CSR_OPT_RB_LO = 4;
   localparam int CSR_OPT_OSC_LO = 6;
   localparam logic [31:0] CSR_OPT_RST = 32'h0000_0000;

   // Readback modes, command is the default
   localparam logic [1:0] CSR_RB_COMMAND = 2'h0;
   localparam logic [1:0] CSR_RB_DISABLE = 2'h1;
   localparam logic [1:0] CSR_RB_ONCE = 2'h2;

   // Oscillator modes, disabled is the default
   localparam logic [1:0] CSR_OSC_OFF = 2'h0;
   localparam logic [1:0] CSR_OSC_ON = 2'h1;
   localparam logic [1:0] CSR_OSC_HALF = 2'h2;

   // ********************
   // Control fields
   // ********************
   localparam int CSR_CTL_LOAD = 0;
   localparam int CSR_CTL_CFG_DONE = 1;
   localparam logic [31:0] CSR_LEN_RST = 32'h0000_0000;

   typedef enum logic [4:0] {
      CSR_S_LOAD = 5'h01,
      CSR_S_STEP1 = 5'h02,
      CSR_S_STEP2 = 5'h04,
      CSR_S_STEP3 = 5'h08,
      CSR_S_USER = 5'h10
   } csr_state_t;

endpackage

// ==== csr_startup.sv ====
/*
 * Configuration end-of-load sequencer with serial readback port.
 * Assumes: APB master on pclk; config clock, readback trigger and finish
 * pin arrive asynchronously and are synchronised here before use.
 */
// What this block does
// - Release finish pin one config clock before or after io blocks go active; when aligned to finish pin, once the length count is reached.
// - Drop internal clear one clock before or after io activation, after by default.
// - Readback starts only on rising edge of the readback trigger pin.
// - One config clock pulse per readback bit; bit shown on data output.
// - Readback mode: disabled, once, or on every command (default).
// - Once mode serves one readback, then ignores triggers until reconfigured.
// - Oscillator disabled, enabled, or enabled and halved; disabled by default.
// - Length count times the switch; align to count or to finish pin.
// - Finish pin is open drain; internal pull-up unless no-pull-up chosen.
`timescale 1ns/100ps
module csr_startup #(
   parameter int RB_LEN = 32
) (
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Configuration link
   input wire logic config_clk,
   input wire logic config_data_in,
   input wire logic config_read_trigger_pin,
   output logic readback_data_out,
   // Finish pin, open drain
   input wire logic finish_pin_in,
   output logic finish_pin_out,
   output logic finish_pin_oe,
   output logic finish_pin_pullup_en,
   // Startup controls
   output logic io_block_active,
   output logic internal_clear,
   output logic low_during_load_output,
   // Crystal oscillator
   input wire logic xtal_in,
   output logic osc_enable,
   output logic osc_out
);

   // ********************
   // Synchronisers
   // ********************
   logic [2:0] sync1_q, sync2_q;
   logic cclk_prev_q, trig_prev_q;
   logic cclk_rise, trig_rise, fin_high;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= 3'h0;
         sync2_q <= 3'h0;
         cclk_prev_q <= 1'b0;
         trig_prev_q <= 1'b0;
      end else begin
         sync1_q <= {finish_pin_in, config_read_trigger_pin, config_clk};
         sync2_q <= sync1_q;
         cclk_prev_q <= sync2_q[0];
         trig_prev_q <= sync2_q[1];
      end
   end
   assign cclk_rise = sync2_q[0] & ~cclk_prev_q;
   assign trig_rise = sync2_q[1] & ~trig_prev_q;
   assign fin_high = sync2_q[2];

   // ********************
   // Registers
   // ********************
   logic [31:0] opt_q, opt_live_q, len_q, bitcnt_q;
   logic load_req_q, cfg_done_q;
   csr_pkg::csr_state_t state_q;
   logic apb_wr, apb_acc;
   assign apb_acc = psel & penable;
   assign apb_wr = apb_acc & pwrite;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         opt_q <= csr_pkg::CSR_OPT_RST;
         len_q <= csr_pkg::CSR_LEN_RST;
      end else if (apb_wr && state_q == csr_pkg::CSR_S_LOAD) begin
         // Options only writable while loading, so user operation sees them fixed
         if (paddr == csr_pkg::CSR_OPT_OFS) opt_q <= pwdata;
         if (paddr == csr_pkg::CSR_LEN_OFS) len_q <= pwdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         load_req_q <= 1'b0;
         cfg_done_q <= 1'b0;
      end else begin
         load_req_q <= apb_wr && paddr == csr_pkg::CSR_CTL_OFS && pwdata[csr_pkg::CSR_CTL_LOAD];
         if (apb_wr && paddr == csr_pkg::CSR_CTL_OFS)
            cfg_done_q <= pwdata[csr_pkg::CSR_CTL_CFG_DONE];
      end
   end

   logic [1:0] rb_mode, osc_mode;
   logic fin_after, clr_before, align_fin;
   assign fin_after = opt_live_q[csr_pkg::CSR_OPT_FIN_AFTER];
   assign clr_before = opt_live_q[csr_pkg::CSR_OPT_CLR_BEFORE];
   assign align_fin = opt_live_q[csr_pkg::CSR_OPT_ALIGN_FIN];
   assign rb_mode = opt_live_q[csr_pkg::CSR_OPT_RB_LO +: 2];
   assign osc_mode = opt_live_q[csr_pkg::CSR_OPT_OSC_LO +: 2];

   // ********************
   // Load and startup sequence
   // ********************
   logic len_reached, go_start, align_wait;
   // Bits counted on config clock edges; host is trusted to send stream order
   assign len_reached = bitcnt_q >= len_q;
   // Pending options decide here: the live copy still holds the last load
   assign go_start = opt_q[csr_pkg::CSR_OPT_ALIGN_FIN] ? (len_reached & fin_high) : len_reached;
   // Own driver lets go first, or the shared finish line could never rise
   assign align_wait = state_q == csr_pkg::CSR_S_LOAD && cfg_done_q && len_reached
                       && opt_q[csr_pkg::CSR_OPT_ALIGN_FIN];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= csr_pkg::CSR_S_LOAD;
         bitcnt_q <= 32'h0;
         opt_live_q <= csr_pkg::CSR_OPT_RST;
      end else if (load_req_q) begin
         state_q <= csr_pkg::CSR_S_LOAD;
         bitcnt_q <= 32'h0;
      end else begin
         unique case (state_q)
            csr_pkg::CSR_S_LOAD: begin
               if (cclk_rise) bitcnt_q <= bitcnt_q + 32'h1;
               if (cfg_done_q && go_start) begin
                  opt_live_q <= opt_q;
                  state_q <= csr_pkg::CSR_S_STEP1;
               end
            end
            csr_pkg::CSR_S_STEP1: if (cclk_rise) state_q <= csr_pkg::CSR_S_STEP2;
            csr_pkg::CSR_S_STEP2: if (cclk_rise) state_q <= csr_pkg::CSR_S_STEP3;
            csr_pkg::CSR_S_STEP3: if (cclk_rise) state_q <= csr_pkg::CSR_S_USER;
            csr_pkg::CSR_S_USER: ;
         endcase
      end
   end

   // Step2 is the io activation cycle; step1 before, step3 after
   logic in_s1p, in_s2p, in_s3p;
   assign in_s1p = state_q != csr_pkg::CSR_S_LOAD;
   assign in_s2p = in_s1p && state_q != csr_pkg::CSR_S_STEP1;
   assign in_s3p = in_s2p && state_q != csr_pkg::CSR_S_STEP2;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         io_block_active <= 1'b0;
         internal_clear <= 1'b1;
         finish_pin_oe <= 1'b1;
         finish_pin_out <= 1'b0;
         finish_pin_pullup_en <= 1'b1;
         low_during_load_output <= 1'b0;
      end else begin
         io_block_active <= in_s2p;
         // Early release keeps loaders from fighting freshly active outputs
         // Finish alignment implies the early release, so no re-drive after the wait
         finish_pin_oe <= ~(align_wait | ((fin_after && !align_fin) ? in_s3p : in_s1p));
         finish_pin_out <= 1'b0;
         finish_pin_pullup_en <= ~opt_q[csr_pkg::CSR_OPT_NOPULL];
         // Late default lets outputs drive while flops are still cleared
         internal_clear <= ~(clr_before ? in_s1p : in_s3p);
         low_during_load_output <= ~in_s2p;
      end
   end

   // ********************
   // Readback
   // ********************
   logic rb_active_q, rb_used_q;
   logic [$clog2(RB_LEN+1)-1:0] rb_idx_q;
   logic rb_allowed;
   assign rb_allowed = rb_mode == csr_pkg::CSR_RB_COMMAND
                       || (rb_mode == csr_pkg::CSR_RB_ONCE && !rb_used_q);
   logic [RB_LEN-1:0] rb_shift_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rb_active_q <= 1'b0;
         rb_used_q <= 1'b0;
         rb_idx_q <= '0;
         rb_shift_q <= '0;
         readback_data_out <= 1'b0;
      end else if (load_req_q) begin
         rb_active_q <= 1'b0;
         rb_used_q <= 1'b0;
      end else if (!rb_active_q) begin
         if (state_q == csr_pkg::CSR_S_USER && trig_rise && rb_allowed) begin
            rb_active_q <= 1'b1;
            rb_used_q <= 1'b1;
            rb_idx_q <= '0;
            rb_shift_q <= opt_live_q[RB_LEN-1:0];
         end
      end else if (cclk_rise) begin
         readback_data_out <= rb_shift_q[RB_LEN-1];
         rb_shift_q <= {rb_shift_q[RB_LEN-2:0], 1'b0};
         rb_idx_q <= rb_idx_q + 1'b1;
         if (rb_idx_q == ($clog2(RB_LEN+1))'(RB_LEN - 1)) rb_active_q <= 1'b0;
      end
   end

   // ********************
   // Oscillator
   // ********************
   logic xtal_s1_q, xtal_s2_q, xtal_prev_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xtal_s1_q <= 1'b0;
         xtal_s2_q <= 1'b0;
         xtal_prev_q <= 1'b0;
         osc_out <= 1'b0;
         osc_enable <= 1'b0;
      end else begin
         xtal_s1_q <= xtal_in;
         xtal_s2_q <= xtal_s1_q;
         xtal_prev_q <= xtal_s2_q;
         osc_enable <= osc_mode != csr_pkg::CSR_OSC_OFF;
         if (osc_mode == csr_pkg::CSR_OSC_OFF) osc_out <= 1'b0;
         else if (osc_mode == csr_pkg::CSR_OSC_HALF) begin
            // Toggle on rising edges only: symmetric at half rate
            if (xtal_s2_q && !xtal_prev_q) osc_out <= ~osc_out;
         end else osc_out <= xtal_s2_q;
      end
   end

   // ********************
   // APB read
   // ********************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= 1'b0;
         if (psel && !penable) begin
            unique case (paddr)
               csr_pkg::CSR_OPT_OFS: prdata <= opt_q;
               csr_pkg::CSR_CTL_OFS: prdata <= {30'h0, cfg_done_q, 1'b0};
               csr_pkg::CSR_STAT_OFS: prdata <= {24'h0, rb_used_q, rb_active_q, fin_high, state_q};
               csr_pkg::CSR_LEN_OFS: prdata <= len_q;
               csr_pkg::CSR_RBD_OFS: prdata <= bitcnt_q;
               default: begin
                  prdata <= 32'h0;
                  pslverr <= 1'b1;
               end
            endcase
         end
      end
   end

endmodule // csr_startup

// ==== csr_startup_sva.sv ====
/* Checker for the startup sequencer pins and the readback port.
   Assumes one pclk domain and the bind at the foot of this file. */
`timescale 1ns/100ps
module csr_startup_sva (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Link and pins
   input wire logic config_clk,
   input wire logic readback_data_out,
   input wire logic finish_pin_out,
   input wire logic finish_pin_oe,
   input wire logic finish_pin_pullup_en,
   input wire logic io_block_active,
   input wire logic internal_clear,
   input wire logic osc_enable,
   input wire logic osc_out
);
   // ****************
   // Properties
   // ****************
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [6:0] cc_q;
   // Raw link clock history, so a readback change can be tied to a recent rise
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cc_q <= 7'h00;
      end else begin
         cc_q <= {cc_q[5:0], config_clk};
      end
   end
   property p_fin_low; !finish_pin_out; endproperty
   a_fin_low: assert property (p_fin_low) else $error("finish pin driven high");
   property p_fin_apart; $rose(io_block_active) |-> $stable(finish_pin_oe); endproperty
   a_fin_apart: assert property (p_fin_apart) else $error("finish moved with io");
   property p_fin_late; $rose(io_block_active) |-> ##[0:40] !finish_pin_oe; endproperty
   a_fin_late: assert property (p_fin_late) else $error("finish never released");
   property p_clr_apart; $rose(io_block_active) |-> $stable(internal_clear); endproperty
   a_clr_apart: assert property (p_clr_apart) else $error("clear moved with io");
   property p_clr_late; $rose(io_block_active) |-> ##[0:40] !internal_clear; endproperty
   a_clr_late: assert property (p_clr_late) else $error("clear never released");
   property p_pull_kept; io_block_active |-> $stable(finish_pin_pullup_en); endproperty
   a_pull_kept: assert property (p_pull_kept) else $error("pull-up changed in use");
   property p_rb_edge; $changed(readback_data_out) |-> |(cc_q[5:0] & ~cc_q[6:1]); endproperty
   a_rb_edge: assert property (p_rb_edge) else $error("readback moved without clock");
   property p_osc_off; !osc_enable [*2] |-> $stable(osc_out); endproperty
   a_osc_off: assert property (p_osc_off) else $error("oscillator runs while off");
endmodule // csr_startup_sva
bind csr_startup csr_startup_sva u_sva (.pclk, .presetn, .config_clk, .readback_data_out, .finish_pin_out,
   .finish_pin_oe, .finish_pin_pullup_en, .io_block_active, .internal_clear, .osc_enable, .osc_out);

// ==== csr_link_model.sv ====
/* Host model: loads bits, clocks startup and reads back.
   Assumes calls start right after a pclk edge. */
`timescale 1ns/100ps
module csr_link_model (
   // Clock
   input wire logic pclk,
   // Link
   output logic config_clk,
   output logic config_data_in,
   output logic config_read_trigger_pin,
   input wire logic readback_data_out
);
   // ****************
   // Host behaviour
   // ****************
   initial begin
      config_clk = 1'b0;
      config_data_in = 1'b0;
      config_read_trigger_pin = 1'b0;
   end
   task automatic pulse(input logic b, input int half, output logic rb);
      config_data_in <= b;
      repeat (half) @(posedge pclk);
      config_clk <= 1'b1;
      repeat (half) @(posedge pclk);
      config_clk <= 1'b0;
      config_data_in <= ~b; // Released line must not keep the old bit
      repeat (half) @(posedge pclk);
      rb = readback_data_out;
   endtask
   task automatic stream(input logic [31:0] w, input int n, input int half);
      logic rb;
      for (int i = n - 1; i >= 0; i--) begin
         pulse(w[i], half, rb);
      end
   endtask
   task automatic read_word(input int half, output logic [31:0] w);
      config_read_trigger_pin <= 1'b1;
      repeat (half) @(posedge pclk);
      config_read_trigger_pin <= 1'b0;
      repeat (half) @(posedge pclk);
      for (int i = 31; i >= 0; i--) begin
         pulse(1'b0, half, w[i]);
      end
   endtask
endmodule // csr_link_model

// ==== csr_startup_tb.sv ====
/* Bench for csr_startup: boots with four option words, reads them back.
   Assumes csr_link_model as host and an external pull-up on the finish pin. */
`timescale 1ns/100ps
module csr_startup_tb;
   // ****************
   // Bench
   // ****************
   logic pclk, pready, pslverr, readback_data_out, finish_pin_out, finish_pin_oe, finish_pin_pullup_en;
   logic presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, xtal_in = 1'b0, fin_hold = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic config_clk, config_data_in, config_read_trigger_pin, io_block_active, internal_clear;
   logic osc_enable, osc_out, low_during_load_output;
   // Pulled up unless the device or an outside holder pulls it low
   wire logic finish_pin_in = ~finish_pin_oe & ~fin_hold;
   int num_errors = 0;
   int samples_checked = 0;
   logic [31:0] opts [4] = '{32'h0000_0000, 32'h0000_006b, 32'h0000_0090, 32'h0000_0004};
   csr_startup #(.RB_LEN(32)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .config_clk, .config_data_in, .config_read_trigger_pin, .readback_data_out, .finish_pin_in,
      .finish_pin_out, .finish_pin_oe, .finish_pin_pullup_en, .io_block_active, .internal_clear,
      .low_during_load_output, .xtal_in, .osc_enable, .osc_out);
   csr_link_model lnk (.pclk, .config_clk, .config_data_in, .config_read_trigger_pin, .readback_data_out);
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   always @(posedge pclk) xtal_in <= ~xtal_in;
   task automatic complete_run();
      if (num_errors == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
      output logic e);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Order: finish drive, io active, clear, pull-up, oscillator
   function automatic logic [31:0] pins();
      return {27'h0, finish_pin_oe, io_block_active, internal_clear, finish_pin_pullup_en, osc_enable};
   endfunction
   task automatic t_reset();
      logic [31:0] r;
      logic e;
      chk(pins(), 32'h0000_0016, "reset pins");
      apb(1'b0, csr_pkg::CSR_OPT_OFS, 32'h0000_0000, r, e);
      chk(r, csr_pkg::CSR_OPT_RST, "option reset");
      apb(1'b0, 8'h20, 32'h0000_0000, r, e);
      chk({31'h0, e}, 32'h0000_0001, "unmapped");
   endtask
   task automatic t_boot(input logic [31:0] o, input int half);
      logic [31:0] r;
      logic e;
      logic prev;
      int n;
      // Finish alignment: an outside holder keeps the line low until checked
      fin_hold <= o[csr_pkg::CSR_OPT_ALIGN_FIN];
      apb(1'b1, csr_pkg::CSR_CTL_OFS, 32'h0000_0001, r, e);
      apb(1'b1, csr_pkg::CSR_OPT_OFS, o, r, e);
      apb(1'b1, csr_pkg::CSR_LEN_OFS, 32'h0000_0010, r, e);
      apb(1'b1, csr_pkg::CSR_CTL_OFS, 32'h0000_0002, r, e);
      lnk.stream(32'h0000_a5c3, 15, half);
      chk(pins() >> 3, 32'h0000_0002, "early start");
      chk({31'h0, low_during_load_output}, 32'h0000_0001, "load low early");
      for (int s = 0; s < 4; s++) begin
         lnk.stream(32'h0000_0001, 1, half);
         if (s == 0 && o[csr_pkg::CSR_OPT_ALIGN_FIN]) begin
            apb(1'b0, csr_pkg::CSR_STAT_OFS, 32'h0000_0000, r, e);
            chk({27'h0, r[4:0]}, 32'(csr_pkg::CSR_S_LOAD), "held by finish pin");
            fin_hold <= 1'b0;
            repeat (8) @(posedge pclk);
         end
         r = {29'h0, o[csr_pkg::CSR_OPT_FIN_AFTER] & ~o[csr_pkg::CSR_OPT_ALIGN_FIN], s[0],
            ~o[csr_pkg::CSR_OPT_CLR_BEFORE]};
         chk(pins() >> 2, (s < 2) ? r : 32'h0000_0002, "startup step");
      end
      r = {27'h0, 3'h2, ~o[csr_pkg::CSR_OPT_NOPULL], o[csr_pkg::CSR_OPT_OSC_LO +: 2] != csr_pkg::CSR_OSC_OFF};
      chk(pins(), r, "user pins");
      chk({31'h0, low_during_load_output}, 32'h0000_0000, "load low in use");
      n = 0;
      for (int c = 0; c < 8; c++) begin
         prev = osc_out;
         @(posedge pclk);
         n += int'(osc_out != prev);
      end
      // Crystal flips every pclk: full rate flips 8 times in 8 cycles, halved 4
      r = (o[csr_pkg::CSR_OPT_OSC_LO +: 2] == csr_pkg::CSR_OSC_ON) ? 32'h0000_0008
         : (o[csr_pkg::CSR_OPT_OSC_LO +: 2] == csr_pkg::CSR_OSC_HALF) ? 32'h0000_0004 : 32'h0000_0000;
      chk(n, r, "oscillator rate");
      apb(1'b1, csr_pkg::CSR_OPT_OFS, ~o, r, e);
      apb(1'b0, csr_pkg::CSR_OPT_OFS, 32'h0000_0000, r, e);
      chk(r, o, "options frozen");
   endtask
   task automatic t_readback(input logic [31:0] o, input int half);
      logic [31:0] got, exp;
      logic [1:0] m;
      logic held;
      m = o[csr_pkg::CSR_OPT_RB_LO +: 2];
      held = readback_data_out;
      lnk.stream(32'h0000_0000, 3, half);
      chk({31'h0, readback_data_out}, {31'h0, held}, "moved untriggered");
      for (int k = 0; k < 2; k++) begin
         held = readback_data_out;
         lnk.read_word(half, got);
         exp = (m == csr_pkg::CSR_RB_COMMAND || (m == csr_pkg::CSR_RB_ONCE && k == 0)) ? o : {32{held}};
         chk(got, exp, "readback");
      end
   endtask
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      // Slower link clock on each pass
      for (int i = 0; i < 4; i++) begin
         t_boot(opts[i], 4 + 2 * i);
         t_readback(opts[i], 4 + 2 * i);
      end
      complete_run();
   end
   initial begin
      repeat (30000) @(posedge pclk);
      num_errors++;
      complete_run();
   end
endmodule // csr_startup_tb
